// >>> design/nvm_pkg.sv
// Constants, states and helpers shared by the data EEPROM access controller
package nvm_pkg;

   localparam int unsigned NVM_DEPTH = 1024;
   localparam int unsigned NVM_AW = 10;
   localparam int unsigned PAGE_BYTES = 16;

   // Register select: sector 0 holds address and data, sector 1 the control
   localparam logic SECTOR_DIRECT = 1'b0;
   localparam logic SECTOR_CONTROL = 1'b1;
   localparam logic [7:0] OFS_ADDR_LOW = 8'h40;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h41;
   localparam logic [7:0] OFS_DATA = 8'h42;
   localparam logic [7:0] OFS_CONTROL = 8'h40;

   // Control register field positions
   localparam int unsigned CTL_RESERVED = 7;
   localparam int unsigned CTL_ERASE_EN = 6;
   localparam int unsigned CTL_ERASE_TRIG = 5;
   localparam int unsigned CTL_PAGE_MODE = 4;
   localparam int unsigned CTL_WRITE_EN = 3;
   localparam int unsigned CTL_WRITE_TRIG = 2;
   localparam int unsigned CTL_READ_EN = 1;
   localparam int unsigned CTL_READ_TRIG = 0;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESET_HIGH = 2'h0;
   localparam logic [7:0] ERASED_BYTE = 8'h00;
   localparam logic [3:0] PAGE_LAST = 4'hF;
   localparam logic [3:0] IDX_FIRST = 4'h0;
   localparam logic [3:0] IDX_BYTE_WRITE = 4'h1;

   // Self-timed erase and write intervals, least times rounded up
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned ERASE_TIME_NS = 2000;
   localparam int unsigned WRITE_TIME_NS = 2000;
   localparam logic [11:0] ERASE_CYCLES =
      12'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] WRITE_CYCLES =
      12'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_READ = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_COMMIT = 4'b1000
   } seq_state_t;

   // In-page increment that stops at the page boundary
   function automatic logic [3:0] sat_inc(input logic [3:0] v);
      sat_inc = (v == PAGE_LAST) ? PAGE_LAST : v + 4'h1;
   endfunction : sat_inc

endpackage : nvm_pkg

// >>> design/nvm_array.sv
// Non-volatile byte array with one write port and a registered read port
`timescale 1ns/1ns
`default_nettype none
module nvm_array (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic we_in,
   input wire logic [nvm_pkg::NVM_AW-1:0] waddr_in,
   input wire logic [7:0] wdata_in,
   input wire logic [nvm_pkg::NVM_AW-1:0] raddr_in,
   output logic [7:0] rdata_out
);
   import nvm_pkg::*;

   // No reset on the cells: contents survive a controller reset
   logic [7:0] mem [NVM_DEPTH];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rdata_out <= RESET_BYTE;
      end else begin
         rdata_out <= mem[raddr_in];
      end
   end
endmodule : nvm_array
`default_nettype wire

// >>> design/nvm_page_buffer.sv
// Sixteen-byte page buffer with per-byte tags for page erase and write
`timescale 1ns/1ns
`default_nettype none
module nvm_page_buffer (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic clear_in,
   input wire logic load_in,
   input wire logic [3:0] load_idx_in,
   input wire logic [7:0] load_data_in,
   input wire logic [3:0] rd_idx_in,
   output logic [7:0] rd_data_out,
   output logic rd_tag_out
);
   import nvm_pkg::*;

   logic [7:0] data_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] tag_q;

   assign rd_data_out = data_q[rd_idx_in];
   assign rd_tag_out = tag_q[rd_idx_in];

   always_ff @(posedge clk_in) begin
      if (!rstn_in || clear_in) begin
         tag_q <= '0;
         for (int i = 0; i < PAGE_BYTES; i++) begin
            data_q[i] <= RESET_BYTE;
         end
      end else if (load_in) begin
         tag_q[load_idx_in] <= 1'b1;
         data_q[load_idx_in] <= load_data_in;
      end
   end
endmodule : nvm_page_buffer
`default_nettype wire

// >>> design/nvm_access.sv
// Data EEPROM access controller: registers, read, erase and write sequencing
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Store 1024 bytes, reachable only through the access registers.
// - Address is 8 low bits plus 2 bits of high register, reset zero.
// - High address register upper six bits read as zero.
// - Control register sits at offset 40H of sector 1, indirect only.
// - Bit 6 enables erase; hardware clears it when erase ends.
// - Bit 5 starts erase only if erase enabled; cleared at end.
// - Bit 4 selects byte or sixteen-byte page operation.
// - Bit 3 enables write; hardware clears it when write ends.
// - Bit 2 starts write only if write enabled; cleared at end.
// - Bit 1 enables reads; low blocks reads.
// - Bit 0 starts read only if read enabled; cleared when done.
// - Byte read loads data register on the same edge that the trigger clears.
// - Data register holds its byte until next read or write.
// - Page read advances address after each byte; re-trigger reads next.
// - Page increment touches low four bits only, saturating at 0FH.
// - Byte write erases the target location first.
// - Page erase leaves the tagged page bytes at zero; untagged bytes keep their value.
module nvm_access (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic sfr_sector_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   output logic busy_out,
   output logic done_out
);
   import nvm_pkg::*;

   logic [7:0] addr_low_q;
   logic [1:0] addr_high_q;
   logic [7:0] data_q;
   logic rsvd_q;
   logic erase_enable_q;
   logic erase_trigger_q;
   logic page_mode_q;
   logic write_enable_q;
   logic write_trigger_q;
   logic read_enable_q;
   logic read_trigger_q;
   logic erase_en_prev_q;
   logic write_en_prev_q;
   logic page_full_q;
   logic is_erase_q;
   logic busy_q;
   logic done_q;
   logic [7:0] rdata_q;
   logic [11:0] timer_q;
   logic [11:0] busy_cnt_q;
   logic [3:0] idx_q;
   seq_state_t state_q;

   // Register decode
   wire sel_low = (sfr_sector_in == SECTOR_DIRECT) && (sfr_addr_in == OFS_ADDR_LOW);
   wire sel_high = (sfr_sector_in == SECTOR_DIRECT) && (sfr_addr_in == OFS_ADDR_HIGH);
   wire sel_data = (sfr_sector_in == SECTOR_DIRECT) && (sfr_addr_in == OFS_DATA);
   wire sel_ctl = (sfr_sector_in == SECTOR_CONTROL) && (sfr_addr_in == OFS_CONTROL);
   wire wr_low = sfr_wr_in && sel_low;
   wire wr_high = sfr_wr_in && sel_high;
   wire wr_data = sfr_wr_in && sel_data;
   wire wr_ctl = sfr_wr_in && sel_ctl;
   wire idle = (state_q == ST_IDLE);

   wire [7:0] ctl_bits = {rsvd_q, erase_enable_q, erase_trigger_q, page_mode_q,
                          write_enable_q, write_trigger_q, read_enable_q, read_trigger_q};
   wire [7:0] read_mux = sel_low ? addr_low_q :
                         sel_high ? {6'h00, addr_high_q} :
                         sel_data ? data_q :
                         sel_ctl ? ctl_bits : RESET_BYTE;

   // Triggers only take effect when the enable was set beforehand and idle
   wire start_erase = wr_ctl && idle && sfr_wdata_in[CTL_ERASE_TRIG] && erase_enable_q;
   wire start_write = wr_ctl && idle && sfr_wdata_in[CTL_WRITE_TRIG] && write_enable_q
                      && !start_erase;
   wire start_read = wr_ctl && idle && sfr_wdata_in[CTL_READ_TRIG] && read_enable_q
                     && !start_erase && !start_write;
   wire ctl_take = wr_ctl && idle;

   wire [NVM_AW-1:0] cur_addr = {addr_high_q, addr_low_q};
   wire [3:0] low_nib = addr_low_q[3:0];

   // Page loads stop once the last slot of the page has been filled
   wire page_load = wr_data && idle && page_mode_q && !page_full_q;
   wire buf_clear = (erase_en_prev_q && !erase_enable_q) || (write_en_prev_q && !write_enable_q);

   wire [7:0] buf_data;
   wire buf_tag;
   wire commit_last = page_mode_q ? (idx_q == PAGE_LAST) :
                      (is_erase_q ? (idx_q == IDX_FIRST) : (idx_q == IDX_BYTE_WRITE));
   wire [NVM_AW-1:0] commit_addr = page_mode_q ? {addr_high_q, addr_low_q[7:4], idx_q} : cur_addr;
   // Byte write first clears the cell, then stores the data byte
   wire pre_erase = !page_mode_q && (idx_q == IDX_FIRST);
   wire [7:0] commit_data = (is_erase_q || pre_erase) ? ERASED_BYTE :
                            (page_mode_q ? buf_data : data_q);
   wire commit_we = (state_q == ST_COMMIT) && (page_mode_q ? buf_tag : 1'b1);
   wire [7:0] array_rdata;

   nvm_array u_array (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .we_in(commit_we),
      .waddr_in(commit_addr),
      .wdata_in(commit_data),
      .raddr_in(cur_addr),
      .rdata_out(array_rdata)
   );

   nvm_page_buffer u_page (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .clear_in(buf_clear),
      .load_in(page_load),
      .load_idx_in(low_nib),
      .load_data_in(sfr_wdata_in),
      .rd_idx_in(idx_q),
      .rd_data_out(buf_data),
      .rd_tag_out(buf_tag)
   );

   // Address registers, with in-page increment on page-mode reads and page loads
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         addr_low_q <= RESET_BYTE;
         addr_high_q <= RESET_HIGH;
         page_full_q <= 1'b0;
      end else if (wr_low || wr_high) begin
         if (wr_low) addr_low_q <= sfr_wdata_in;
         if (wr_high) addr_high_q <= sfr_wdata_in[1:0];
         page_full_q <= 1'b0;
      end else if ((state_q == ST_READ && page_mode_q) || page_load) begin
         addr_low_q[3:0] <= sat_inc(low_nib);
         page_full_q <= page_load && (low_nib == PAGE_LAST);
      end
   end

   // Data register changes only on software write or a completed read
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         data_q <= RESET_BYTE;
      end else if (wr_data) begin
         data_q <= sfr_wdata_in;
      end else if (state_q == ST_READ) begin
         data_q <= array_rdata;
      end
   end

   // Control bits; writes during a busy cycle are dropped whole
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         {rsvd_q, erase_enable_q, page_mode_q, write_enable_q, read_enable_q} <= 5'h00;
      end else if (state_q == ST_COMMIT && commit_last) begin
         erase_enable_q <= is_erase_q ? 1'b0 : erase_enable_q;
         write_enable_q <= is_erase_q ? write_enable_q : 1'b0;
      end else if (ctl_take) begin
         rsvd_q <= sfr_wdata_in[CTL_RESERVED];
         erase_enable_q <= sfr_wdata_in[CTL_ERASE_EN];
         page_mode_q <= sfr_wdata_in[CTL_PAGE_MODE];
         write_enable_q <= sfr_wdata_in[CTL_WRITE_EN];
         read_enable_q <= sfr_wdata_in[CTL_READ_EN];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         erase_en_prev_q <= 1'b0;
         write_en_prev_q <= 1'b0;
      end else begin
         erase_en_prev_q <= erase_enable_q;
         write_en_prev_q <= write_enable_q;
      end
   end

   // Sequencer: read is one cycle, erase and write are self-timed
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         state_q <= ST_IDLE;
         timer_q <= 12'h000;
         idx_q <= IDX_FIRST;
         is_erase_q <= 1'b0;
         erase_trigger_q <= 1'b0;
         write_trigger_q <= 1'b0;
         read_trigger_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               idx_q <= IDX_FIRST;
               if (start_erase || start_write) begin
                  state_q <= ST_WAIT;
                  is_erase_q <= start_erase;
                  erase_trigger_q <= start_erase;
                  write_trigger_q <= start_write;
                  timer_q <= (start_erase ? ERASE_CYCLES : WRITE_CYCLES) - 12'h001;
                  busy_q <= 1'b1;
               end else if (start_read) begin
                  state_q <= ST_READ;
                  read_trigger_q <= 1'b1;
               end
            end
            ST_READ: begin
               state_q <= ST_IDLE;
               read_trigger_q <= 1'b0;
            end
            ST_WAIT: begin
               if (timer_q == 12'h000) begin
                  state_q <= ST_COMMIT;
               end else begin
                  timer_q <= timer_q - 12'h001;
               end
            end
            ST_COMMIT: begin
               if (commit_last) begin
                  state_q <= ST_IDLE;
                  erase_trigger_q <= 1'b0;
                  write_trigger_q <= 1'b0;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end else begin
                  idx_q <= idx_q + 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rdata_q <= RESET_BYTE;
      end else if (sfr_rd_in) begin
         rdata_q <= read_mux;
      end
   end

   assign sfr_rdata_out = rdata_q;
   assign busy_out = busy_q;
   assign done_out = done_q;

   // Length of the busy interval, read only by the timing check below
   always_ff @(posedge clk_in) begin
      if (!rstn_in || !busy_q) begin
         busy_cnt_q <= 12'h000;
      end else begin
         busy_cnt_q <= busy_cnt_q + 12'h001;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   sequence read_taken_s;
      start_read;
   endsequence
   sequence read_lands_s;
      ##2 (!read_trigger_q && data_q == $past(array_rdata));
   endsequence

   high_read_zero_a: assert property (sfr_rd_in && sel_high |=> sfr_rdata_out[7:2] == 6'h00)
      else $error("high address upper bits not zero");
   erase_gate_a: assert property (wr_ctl && idle && !erase_enable_q |=> !erase_trigger_q)
      else $error("erase started without enable");
   write_gate_a: assert property (wr_ctl && idle && !write_enable_q |=> !write_trigger_q)
      else $error("write started without enable");
   read_gate_a: assert property (wr_ctl && !read_enable_q && !read_trigger_q |=> !read_trigger_q)
      else $error("read started without enable");
   read_done_a: assert property (read_taken_s |-> read_lands_s)
      else $error("read data or trigger clear wrong");
   page_sat_a: assert property (state_q == ST_READ && page_mode_q && !wr_low && !wr_high
      |=> addr_low_q[3:0] == sat_inc($past(low_nib))
          && addr_low_q[7:4] == $past(addr_low_q[7:4]) && $stable(addr_high_q))
      else $error("page increment wrong");
   done_clear_a: assert property (done_q |-> !erase_trigger_q && !write_trigger_q
      && !busy_q && (!erase_enable_q || !write_enable_q))
      else $error("completion without clearing");
   busy_ignore_a: assert property (busy_q && !read_trigger_q |=> !read_trigger_q)
      else $error("read accepted while busy");
   data_hold_a: assert property (idle && !wr_data |=> $stable(data_q))
      else $error("data register changed unprompted");
   erase_time_a: assert property (start_erase |=> busy_q [*8])
      else $error("erase ended too early");
   byte_write_a: assert property (state_q == ST_COMMIT && !page_mode_q && !is_erase_q
      && idx_q == IDX_FIRST |-> commit_we && commit_data == ERASED_BYTE)
      else $error("byte write not pre-erased");
   busy_time_a: assert property (done_q |->
      busy_cnt_q >= (is_erase_q ? ERASE_CYCLES : WRITE_CYCLES))
      else $error("erase or write ended early");
   done_pulse_a: assert property (done_q |=> !done_q)
      else $error("completion pulse longer than one cycle");
   wait_flags_a: assert property (state_q == ST_WAIT |-> busy_q && (erase_trigger_q || write_trigger_q))
      else $error("trigger or busy dropped during timed wait");
endmodule : nvm_access
`default_nettype wire

// >>> design/nvm_access_note.sv
// Spare design unit: holds no logic of its own

// >>> test/tb_nvm_access.sv
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/1ns
`default_nettype none
module tb_nvm_access;
   import nvm_pkg::*;
   logic clk_in, rstn_in, sfr_sector_in, sfr_wr_in, sfr_rd_in;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
   logic busy_out, done_out;
   int bad_count, compares;
   int mdl [int];
   logic [31:0] seed;
   logic [7:0] v, d;
   int a, base;
   logic [7:0] trig [3] = '{8'h01, 8'h04, 8'h20};

   nvm_access DUT (.clk_in(clk_in), .rstn_in(rstn_in), .sfr_sector_in(sfr_sector_in),
      .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .busy_out(busy_out),
      .done_out(done_out));

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
   endfunction : xs

   task automatic end_sim;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic chk_flag(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_flag

   task automatic timeout;
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim();
   endtask : timeout

   task automatic note(input string s);
      $display("test %s finished", s);
   endtask : note

   // Strobe held from one edge to the next, then a free edge before reuse
   task automatic wr(input logic s, input logic [7:0] o, input logic [7:0] dat);
      @(posedge clk_in);
      sfr_sector_in <= s;
      sfr_addr_in <= o;
      sfr_wdata_in <= dat;
      sfr_wr_in <= 1'b1;
      @(posedge clk_in);
      sfr_wr_in <= 1'b0;
   endtask : wr

   task automatic rd(input logic s, input logic [7:0] o);
      @(posedge clk_in);
      sfr_sector_in <= s;
      sfr_addr_in <= o;
      sfr_rd_in <= 1'b1;
      @(posedge clk_in);
      sfr_rd_in <= 1'b0;
      #1;
      v = sfr_rdata_out;
   endtask : rd

   // Callers keep reserved bit 7 low in every control value
   task automatic ctl(input logic [7:0] dat);
      wr(SECTOR_CONTROL, OFS_CONTROL, dat);
   endtask : ctl

   task automatic setad(input int ad);
      wr(SECTOR_DIRECT, OFS_ADDR_LOW, 8'(ad));
      wr(SECTOR_DIRECT, OFS_ADDR_HIGH, 8'(ad >> 8));
   endtask : setad

   // Bounded wait for completion; no register change until it ends
   // pre counts trigger-to-call edges already spent by the caller
   task automatic wait_done(input int pre);
      int n;
      #1;
      chk_flag(busy_out, 1'b1);
      n = pre;
      while (done_out !== 1'b1) begin
         @(posedge clk_in);
         #1;
         n++;
         if (n > 600) timeout();
      end
      chk_flag(n >= int'(WRITE_CYCLES) - 1, 1'b1);
      chk_flag(busy_out, 1'b0);
      @(posedge clk_in);
      #1;
      chk_flag(done_out, 1'b0);
   endtask : wait_done

   // Trigger one read, poll the trigger bit until it clears, fetch the data register
   task automatic trig_read(input logic [7:0] m);
      int n;
      ctl(8'h03 | m);
      n = 0;
      do begin
         rd(SECTOR_CONTROL, OFS_CONTROL);
         n++;
         if (n > 8) timeout();
      end while (v[0] !== 1'b0);
      rd(SECTOR_DIRECT, OFS_DATA);
   endtask : trig_read

   initial begin
      seed = 32'h93F0;
      bad_count = 0;
      compares = 0;
      rstn_in = 1'b0;
      sfr_sector_in = 1'b0;
      sfr_addr_in = 8'h00;
      sfr_wdata_in = 8'h00;
      sfr_wr_in = 1'b0;
      sfr_rd_in = 1'b0;
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(SECTOR_DIRECT, OFS_ADDR_LOW);
      chk(v, 8'h00);
      rd(SECTOR_DIRECT, OFS_DATA);
      chk(v, 8'h00);
      // Same offset in sector 0 must not reach the control register
      wr(SECTOR_DIRECT, OFS_CONTROL, 8'h02);
      rd(SECTOR_CONTROL, OFS_CONTROL);
      chk(v, 8'h00);
      wr(SECTOR_DIRECT, 8'h43, 8'hA5);
      rd(SECTOR_DIRECT, 8'h43);
      chk(v, 8'h00);
      wr(SECTOR_DIRECT, OFS_ADDR_HIGH, 8'hFF);
      rd(SECTOR_DIRECT, OFS_ADDR_HIGH);
      chk(v, 8'h03);
      for (int i = 0; i < 3; i++) begin
         ctl(trig[i]);
         #1;
         chk_flag(busy_out, 1'b0);
         rd(SECTOR_CONTROL, OFS_CONTROL);
         chk(v, 8'h00);
      end
      note("reset_and_gating");
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         a = int'(seed[9:0]);
         seed = xs(seed);
         d = seed[7:0];
         setad(a);
         wr(SECTOR_DIRECT, OFS_DATA, d);
         ctl(8'h08); // Enable first, trigger on the next write
         ctl(8'h0C);
         ctl(8'h4C); // Raises one enable only; dropped whole while busy
         rd(SECTOR_CONTROL, OFS_CONTROL);
         chk(v, 8'h0C);
         wait_done(4); // Four edges spent by the two accesses above
         mdl[a] = int'(d);
         rd(SECTOR_CONTROL, OFS_CONTROL);
         chk(v, 8'h00);
         ctl(8'h02);
         trig_read(8'h00);
         chk(v, 8'(mdl[a]));
         setad(a ^ 1);
         rd(SECTOR_DIRECT, OFS_DATA);
         chk(v, d);
      end
      setad(a);
      ctl(8'h40); // Erase enable first, trigger on the next write
      ctl(8'h60);
      wait_done(0);
      mdl[a] = 0;
      rd(SECTOR_CONTROL, OFS_CONTROL);
      chk(v, 8'h00);
      ctl(8'h02);
      trig_read(8'h00);
      chk(v, 8'(mdl[a]));
      note("byte_ops");
      seed = xs(seed);
      base = int'(seed[9:4]) << 4;
      setad(base);
      ctl(8'h10);
      // Seventeenth byte falls on a full page and must be dropped
      for (int i = 0; i < 17; i++) begin
         seed = xs(seed);
         wr(SECTOR_DIRECT, OFS_DATA, seed[7:0]);
         if (i < 16) mdl[base + i] = int'(seed[7:0]);
      end
      rd(SECTOR_DIRECT, OFS_ADDR_LOW);
      chk(v, 8'(base) | 8'h0F);
      ctl(8'h18);
      ctl(8'h1C);
      wait_done(0);
      rd(SECTOR_CONTROL, OFS_CONTROL);
      chk(v & 8'h6C, 8'h00);
      setad(base);
      ctl(8'h12);
      for (int i = 0; i < 17; i++) begin
         trig_read(8'h10);
         chk(v, 8'(mdl[base + (i > 15 ? 15 : i)]));
      end
      rd(SECTOR_DIRECT, OFS_ADDR_LOW);
      chk(v, 8'(base) | 8'h0F);
      rd(SECTOR_DIRECT, OFS_ADDR_HIGH);
      chk(v, 8'(base >> 8));
      note("page_write_read");
      // Only the two tagged slots may be cleared
      setad(base);
      ctl(8'h10);
      wr(SECTOR_DIRECT, OFS_DATA, 8'h5A);
      wr(SECTOR_DIRECT, OFS_DATA, 8'h5A);
      ctl(8'h50);
      ctl(8'h70);
      wait_done(0);
      mdl[base] = 0;
      mdl[base + 1] = 0;
      rd(SECTOR_CONTROL, OFS_CONTROL);
      chk(v & 8'h6C, 8'h00);
      setad(base);
      ctl(8'h12);
      for (int i = 0; i < 3; i++) begin
         trig_read(8'h10);
         chk(v, 8'(mdl[base + i]));
      end
      note("page_erase");
      end_sim();
   end
endmodule : tb_nvm_access
`default_nettype wire
